// ### verilog/tmr_map.svh
// Reset values and fixed counter levels of the timer channel
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH
`define CNT_RESET 16'hffff
`define CNT_ZERO 16'h0000
`define CNT_STOP 16'hffff
`define CNT_ONE 16'h0001
`define DATA_RESET 16'h0000
`define OUT_RESET 1'b0
`define FLAG_RESET 1'b0
`endif

// ### verilog/tmr_pkg.sv
// Types shared by the timer channel modules
package tmr_pkg;
    typedef logic [15:0] cnt_t;
    typedef enum logic [2:0] {
        MODE_INTERVAL,
        MODE_EVENT,
        MODE_CAPTURE,
        MODE_ONECOUNT,
        MODE_CAP_ONE
    } mode_e;
    typedef enum logic [1:0] {
        EDGE_FALL,
        EDGE_RISE,
        EDGE_BOTH
    } edge_e;
endpackage

// ### verilog/out_if.sv
// Signals between the channel core and its output stage
`timescale 1ns/1ns
interface out_if;
    logic own_int;
    logic master_int;
    logic mode_slave;
    logic pol;
    logic enable;
    logic sw_we;
    logic sw_val;
    logic level;
    modport core (
        output own_int, master_int, mode_slave, pol, enable, sw_we, sw_val,
        input level
    );
    modport drv (
        input own_int, master_int, mode_slave, pol, enable, sw_we, sw_val,
        output level
    );
endinterface

// ### verilog/pin_edge.sv
// Timer input pin synchroniser and edge detector
`timescale 1ns/1ns
`include "tmr_map.svh"
module pin_edge (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Pin
    input wire logic pin_i,
    // Edge pulses
    output logic rise_o,
    output logic fall_o
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic lvl_reg;
    logic rise_reg;
    logic fall_reg;
    wire agree = (s2_reg == s3_reg);
    wire rise_next = agree & s3_reg & ~lvl_reg;
    wire fall_next = agree & ~s3_reg & lvl_reg;

    // Level only moves once two stages agree, so a metastable bit cannot glitch
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            s1_reg <= `FLAG_RESET;
            s2_reg <= `FLAG_RESET;
            s3_reg <= `FLAG_RESET;
            lvl_reg <= `FLAG_RESET;
            rise_reg <= `FLAG_RESET;
            fall_reg <= `FLAG_RESET;
        end else begin
            s1_reg <= pin_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (agree) begin
                lvl_reg <= s3_reg;
            end
            rise_reg <= rise_next;
            fall_reg <= fall_next;
        end
    end

    assign rise_o = rise_reg;
    assign fall_o = fall_reg;
endmodule

// ### verilog/out_drive.sv
// Channel output bit: toggle, set/reset and software write
`timescale 1ns/1ns
`include "tmr_map.svh"
module out_drive (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Core side
    out_if.drv bus
);
    logic level_reg;
    logic level_next;
    wire set_ev = bus.pol ? bus.own_int : bus.master_int;
    wire clr_ev = bus.pol ? bus.master_int : bus.own_int;

    always_comb begin
        level_next = level_reg;
        if (!bus.enable) begin
            if (bus.sw_we) begin
                level_next = bus.sw_val;
            end
        end else if (bus.mode_slave) begin
            if (clr_ev) begin
                level_next = 1'b0;
            end else if (set_ev) begin
                level_next = 1'b1;
            end
        end else if (bus.own_int) begin
            level_next = ~level_reg;
        end
    end

    // Software writes never reach the bit while enabled
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            level_reg <= `OUT_RESET;
        end else begin
            level_reg <= level_next;
        end
    end

    assign bus.level = level_reg;
endmodule

// ### verilog/tmr_channel.sv
// One timer channel: 16-bit counter in five modes and its output bit
// Overview of operation
// - Interval start sets enable, counter holds
// - First count clock loads data, counts down
// - Start interrupt when select bit set
// - Interval zero: interrupt, reload, keep counting
// - Event mode loads data on start write
// - Event mode decrements per valid input edge
// - Capture start trigger clears counter
// - Capture edge copies counter, interrupts, restarts
// - One-count waits rising edge, then loads
// - One-count zero: interrupt, FFFFH, stop
// - High width: rise clears, fall captures
// - Master output mode toggles, ignores polarity
// - Slave mode polarity selects set/reset
// - Simultaneous set and reset: reset wins
// - Enabled output ignores software writes
// - Disabled output takes writes, not interrupts
// - Output level readable at all times
// - Output settings never touch counter/data
// - Only channels 0 and 2 master
// - Divided clock gives one-cycle enable pulse
`timescale 1ns/1ns
`include "tmr_map.svh"
module tmr_channel #(
    parameter int CHAN_NUM = 1,
    parameter int MASTER_NUM = 0
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Channel control
    input wire tmr_pkg::mode_e mode_i,
    input wire tmr_pkg::edge_e valid_edge_i,
    input wire logic start_interrupt_select_i,
    input wire logic channel_start_bit_i,
    input wire logic channel_stop_i,
    // Count clock
    input wire logic div_sel_i,
    input wire logic div_clk_i,
    // Data register write
    input wire logic data_we_i,
    input wire tmr_pkg::cnt_t data_wr_i,
    // Timer input pin
    input wire logic timer_input_pin_i,
    // Output control
    input wire logic output_mode_bit_i,
    input wire logic output_polarity_bit_i,
    input wire logic output_enable_bit_i,
    input wire logic out_we_i,
    input wire logic out_wr_i,
    input wire logic master_timer_interrupt_i,
    // Status
    output logic channel_enable_flag_o,
    output tmr_pkg::cnt_t channel_counter_o,
    output tmr_pkg::cnt_t channel_data_register_o,
    output logic timer_interrupt_o,
    output logic output_value_register_o
);
    // Pairing allowed for this channel
    localparam bit SLAVE_OK =
        ((MASTER_NUM == 0) && (CHAN_NUM >= 1)) ||
        ((MASTER_NUM == 2) && (CHAN_NUM == 3));

    generate
        if ((CHAN_NUM < 0) || (CHAN_NUM > 3)) begin : g_bad_chan
            $error("CHAN_NUM must be 0 to 3");
        end
        if ((MASTER_NUM != 0) && (MASTER_NUM != 2)) begin : g_bad_master
            $error("MASTER_NUM must be 0 or 2");
        end
        if ($bits(tmr_pkg::cnt_t) != 16) begin : g_bad_width
            $error("Counter type must be 16 bits wide");
        end
    endgenerate

    logic en_reg;
    logic en_next;
    logic run_reg;
    logic run_next;
    tmr_pkg::cnt_t cnt_reg;
    tmr_pkg::cnt_t cnt_next;
    tmr_pkg::cnt_t data_reg;
    tmr_pkg::cnt_t data_next;
    logic int_reg;
    logic int_next;
    logic div_prev_reg;

    logic pin_rise;
    logic pin_fall;

    // Count clock enable
    wire div_rise = div_clk_i & ~div_prev_reg;
    wire tclk = div_sel_i ? div_rise : 1'b1;

    // Input edge selection
    wire edge_rise = (valid_edge_i == tmr_pkg::EDGE_RISE);
    wire edge_fall = (valid_edge_i == tmr_pkg::EDGE_FALL);
    wire edge_both = (valid_edge_i == tmr_pkg::EDGE_BOTH);
    wire valid_edge = (edge_rise & pin_rise) |
        (edge_fall & pin_fall) |
        (edge_both & (pin_rise | pin_fall));

    // Mode decode
    wire m_int = (mode_i == tmr_pkg::MODE_INTERVAL);
    wire m_evt = (mode_i == tmr_pkg::MODE_EVENT);
    wire m_cap = (mode_i == tmr_pkg::MODE_CAPTURE);
    wire m_one = (mode_i == tmr_pkg::MODE_ONECOUNT);
    wire m_hw = (mode_i == tmr_pkg::MODE_CAP_ONE);

    wire at_zero = (cnt_reg == `CNT_ZERO);
    wire waiting = en_reg & ~run_reg;
    wire running = en_reg & run_reg;
    wire [15:0] cnt_down = cnt_reg - `CNT_ONE;
    wire [15:0] cnt_up = cnt_reg + `CNT_ONE;

    // Interval triggers
    wire int_start = m_int & waiting & tclk;
    wire int_tick = m_int & running & tclk;

    // Event and capture triggers
    wire evt_tick = m_evt & running & valid_edge;
    wire cap_start = m_cap & waiting & tclk;
    wire cap_hit = m_cap & running & valid_edge;
    wire cap_tick = m_cap & running & tclk;

    // One-count start uses the pin rise whatever the edge select; counting uses tclk
    wire one_start = m_one & waiting & pin_rise;
    wire one_tick = m_one & running & tclk;

    // High width: rise opens, fall closes
    wire hw_start = m_hw & waiting & pin_rise;
    wire hw_end = m_hw & running & pin_fall;
    wire hw_tick = m_hw & running & tclk;

    pin_edge u_pin (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .pin_i(timer_input_pin_i),
        .rise_o(pin_rise),
        .fall_o(pin_fall)
    );

    always_comb begin
        en_next = en_reg;
        run_next = run_reg;
        cnt_next = cnt_reg;
        data_next = data_reg;
        int_next = 1'b0;
        if (data_we_i) begin
            data_next = data_wr_i;
        end
        if (channel_stop_i) begin
            en_next = 1'b0;
            run_next = 1'b0;
        end else if (channel_start_bit_i) begin
            // Restart waits for the next trigger, counter unchanged; event mode loads data and runs at once
            en_next = 1'b1;
            run_next = 1'b0;
            if (m_evt) begin
                cnt_next = data_next;
                run_next = 1'b1;
            end
        end else if (m_int) begin
            if (int_start) begin
                cnt_next = data_reg;
                run_next = 1'b1;
                int_next = start_interrupt_select_i;
            end else if (int_tick) begin
                if (at_zero) begin
                    cnt_next = data_reg;
                    int_next = 1'b1;
                end else begin
                    cnt_next = cnt_down;
                end
            end
        end else if (m_evt) begin
            if (evt_tick) begin
                if (at_zero) begin
                    cnt_next = data_reg;
                    int_next = 1'b1;
                end else begin
                    cnt_next = cnt_down;
                end
            end
        end else if (m_cap) begin
            if (cap_start) begin
                cnt_next = `CNT_ZERO;
                run_next = 1'b1;
                int_next = start_interrupt_select_i;
            end else if (cap_hit) begin
                // First capture after start has no meaning
                data_next = cnt_reg;
                cnt_next = `CNT_ZERO;
                int_next = 1'b1;
            end else if (cap_tick) begin
                cnt_next = cnt_up;
            end
        end else if (m_one) begin
            if (one_start) begin
                cnt_next = data_reg;
                run_next = 1'b1;
            end else if (one_tick) begin
                if (at_zero) begin
                    cnt_next = `CNT_STOP;
                    run_next = 1'b0;
                    int_next = 1'b1;
                end else begin
                    cnt_next = cnt_down;
                end
            end
        end else if (m_hw) begin
            if (hw_start) begin
                cnt_next = `CNT_ZERO;
                run_next = 1'b1;
            end else if (hw_end) begin
                data_next = cnt_reg;
                run_next = 1'b0;
                int_next = 1'b1;
            end else if (hw_tick) begin
                cnt_next = cnt_up;
            end
        end
    end

    // Counter state only; output settings have no path in here
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            en_reg <= `FLAG_RESET;
        end else begin
            en_reg <= en_next;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            run_reg <= `FLAG_RESET;
        end else begin
            run_reg <= run_next;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cnt_reg <= `CNT_RESET;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            data_reg <= `DATA_RESET;
        end else begin
            data_reg <= data_next;
        end
    end

    // One-cycle pulse, dropped in every cycle that does not set it
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            int_reg <= `FLAG_RESET;
        end else begin
            int_reg <= int_next;
        end
    end

    // Previous level, so a divided clock held high counts only once
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            div_prev_reg <= `FLAG_RESET;
        end else begin
            div_prev_reg <= div_clk_i;
        end
    end

    out_if ob ();

    assign ob.own_int = int_reg;
    assign ob.master_int = SLAVE_OK ? master_timer_interrupt_i : 1'b0;
    assign ob.mode_slave = SLAVE_OK & output_mode_bit_i;
    assign ob.pol = output_polarity_bit_i;
    assign ob.enable = output_enable_bit_i;
    assign ob.sw_we = out_we_i;
    assign ob.sw_val = out_wr_i;

    out_drive u_out (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .bus(ob.drv)
    );

    // Status outputs
    assign channel_enable_flag_o = en_reg;
    assign channel_counter_o = cnt_reg;
    assign channel_data_register_o = data_reg;
    assign timer_interrupt_o = int_reg;
    assign output_value_register_o = ob.level;
endmodule

// ### sim/pin_src.sv
// Model of the external source on the timer input pin
`timescale 1ns/1ns
module pin_src (
    // Clock
    input wire logic mclk_i,
    // Pin
    output logic pin_o
);
    initial pin_o = 1'h0;
    // Changes just after an edge so the sampling flops never see a race
    task automatic pulse(input int hi, input int lo);
        @(posedge mclk_i) pin_o <= 1'h1;
        repeat (hi) @(posedge mclk_i);
        pin_o <= 1'h0;
        repeat (lo - 1) @(posedge mclk_i);
    endtask
endmodule

// ### sim/tmr_channel_props.sv
// Concurrent checks on the timer channel ports
`timescale 1ns/1ns
module tmr_channel_props (
    // Clock, reset and control
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire tmr_pkg::mode_e mode_i,
    input wire logic start_interrupt_select_i,
    input wire logic channel_start_bit_i,
    input wire logic channel_stop_i,
    input wire logic div_sel_i,
    input wire logic data_we_i,
    // Output control
    input wire logic output_mode_bit_i,
    input wire logic output_enable_bit_i,
    input wire logic out_we_i,
    input wire logic out_wr_i,
    // Status
    input wire logic channel_enable_flag_o,
    input wire tmr_pkg::cnt_t channel_counter_o,
    input wire tmr_pkg::cnt_t channel_data_register_o,
    input wire logic timer_interrupt_o,
    input wire logic output_value_register_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    wire logic calm = !channel_stop_i && !channel_start_bit_i && !data_we_i;
    wire logic go = channel_start_bit_i && !channel_stop_i && !div_sel_i && !data_we_i;
    wire logic run = channel_enable_flag_o && calm && !div_sel_i;
    wire logic zero = channel_counter_o == 16'h0000;
    wire logic oen = output_enable_bit_i && !output_mode_bit_i;

    intv_load_a: assert property (go && mode_i == tmr_pkg::MODE_INTERVAL ##1 calm
        |=> channel_counter_o == channel_data_register_o) else $error("no load at start");
    start_irq_a: assert property (go && mode_i != tmr_pkg::MODE_EVENT ##1 calm
        |=> timer_interrupt_o == start_interrupt_select_i || mode_i > tmr_pkg::MODE_CAPTURE)
        else $error("start interrupt wrong");
    intv_reload_a: assert property (run && $past(channel_enable_flag_o) && zero
        && mode_i == tmr_pkg::MODE_INTERVAL |=> timer_interrupt_o
        && channel_counter_o == channel_data_register_o) else $error("no reload");
    event_load_a: assert property (go && mode_i == tmr_pkg::MODE_EVENT
        |=> channel_counter_o == $past(channel_data_register_o)) else $error("no event load");
    cap_clear_a: assert property (go && mode_i == tmr_pkg::MODE_CAPTURE ##1 calm
        |=> zero) else $error("capture start not cleared");
    one_end_a: assert property (run && $past(channel_enable_flag_o) && zero
        && mode_i == tmr_pkg::MODE_ONECOUNT |=> timer_interrupt_o
        && channel_counter_o == 16'hffff) else $error("one-count end wrong");
    toggle_a: assert property (oen && $past(oen) && timer_interrupt_o
        |=> $changed(output_value_register_o)) else $error("no toggle");
    out_hold_a: assert property (oen && $past(oen) && !timer_interrupt_o
        |=> $stable(output_value_register_o)) else $error("output moved");
    sw_write_a: assert property (!output_enable_bit_i && out_we_i
        |=> output_value_register_o == $past(out_wr_i)) else $error("write lost");

    cover property (go && mode_i == tmr_pkg::MODE_CAPTURE);
    cover property (timer_interrupt_o && oen);
    cover property (out_we_i && !output_enable_bit_i);
endmodule

bind tmr_channel tmr_channel_props i_props (.mclk_i(mclk_i), .rst_i(rst_i),
    .mode_i(mode_i), .start_interrupt_select_i(start_interrupt_select_i),
    .channel_start_bit_i(channel_start_bit_i), .channel_stop_i(channel_stop_i),
    .div_sel_i(div_sel_i), .data_we_i(data_we_i), .output_mode_bit_i(output_mode_bit_i),
    .output_enable_bit_i(output_enable_bit_i), .out_we_i(out_we_i), .out_wr_i(out_wr_i),
    .channel_enable_flag_o(channel_enable_flag_o), .channel_counter_o(channel_counter_o),
    .channel_data_register_o(channel_data_register_o),
    .timer_interrupt_o(timer_interrupt_o),
    .output_value_register_o(output_value_register_o));

// ### sim/testbench.sv
// Self-checking bench for one timer channel
`timescale 1ns/1ns
module testbench;
    logic mclk_i = 1'h0;
    logic rst_i = 1'h1;
    tmr_pkg::mode_e mode = tmr_pkg::MODE_INTERVAL;
    logic sel = 1'h1, start = 1'h0, stop = 1'h0, dwe = 1'h0, mi = 1'h0;
    logic omode = 1'h0, opol = 1'h0, oen = 1'h0, owe = 1'h0, owr = 1'h0;
    tmr_pkg::cnt_t dwr = 16'h0000;
    tmr_pkg::edge_e vedge = tmr_pkg::EDGE_RISE;
    logic dsel = 1'h0, divc = 1'h0;
    tmr_pkg::cnt_t cnt, dat;
    logic en, irq, outv, pin;
    logic [16:0] note;
    logic [16:0] exp_q[$];
    logic [31:0] rs = 32'h0000ac96;
    int fail_count = 0;
    int total_checks = 0;

    tmr_channel i_tmr_channel (.mclk_i(mclk_i), .rst_i(rst_i), .mode_i(mode),
        .valid_edge_i(vedge), .start_interrupt_select_i(sel),
        .channel_start_bit_i(start), .channel_stop_i(stop), .div_sel_i(dsel),
        .div_clk_i(divc), .data_we_i(dwe), .data_wr_i(dwr), .timer_input_pin_i(pin),
        .output_mode_bit_i(omode), .output_polarity_bit_i(opol),
        .output_enable_bit_i(oen), .out_we_i(owe), .out_wr_i(owr),
        .master_timer_interrupt_i(mi), .channel_enable_flag_o(en),
        .channel_counter_o(cnt), .channel_data_register_o(dat),
        .timer_interrupt_o(irq), .output_value_register_o(outv));
    pin_src i_pin_src (.mclk_i(mclk_i), .pin_o(pin));

    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    task automatic check(string what, tmr_pkg::cnt_t e, tmr_pkg::cnt_t g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge mclk_i);
    endtask
    // Stop first: mode may only change while the channel is idle
    task automatic run(tmr_pkg::mode_e m, tmr_pkg::cnt_t d);
        stop <= 1'h1;
        tick(1);
        stop <= 1'h0;
        mode <= m;
        dwe <= 1'h1;
        dwr <= d;
        tick(1);
        dwe <= 1'h0;
        start <= 1'h1;
        tick(1);
        start <= 1'h0;
    endtask
    task automatic drain();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 3000) begin
            tick(1);
            n++;
        end
        stop <= 1'h1;
        tick(1);
        stop <= 1'h0;
        check("pending", 16'h0000, 16'(exp_q.size()));
    endtask
    task automatic summarize();
        if (fail_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        forever #5 mclk_i = ~mclk_i;
    end
    // Divided clock at half the rate, only used while dsel is high
    always @(posedge mclk_i) divc <= ~divc;
    // Each interrupt consumes the oldest note; a spare one meets ffff and fails
    always @(posedge mclk_i) begin
        if (!rst_i && irq === 1'h1) begin
            note = (exp_q.size() != 0) ? exp_q.pop_front() : 17'h1ffff;
            if (note[16]) check("data", note[15:0], dat);
        end
    end
    initial begin
        #300000;
        fail_count++;
        summarize();
    end

    initial begin
        tmr_pkg::cnt_t d;
        int n;
        logic [31:0] b;
        tick(10);
        rst_i <= 1'h0;
        tick(6);
        d = 16'(rnd() % 8 + 3);
        owe <= 1'h1;
        tick(1);
        owe <= 1'h0;
        oen <= 1'h1;
        owr <= 1'h1;
        tick(1);
        owe <= 1'h1;
        tick(1);
        owe <= 1'h0;
        repeat (3) exp_q.push_back({1'h1, d});
        run(tmr_pkg::MODE_INTERVAL, d);
        drain();
        tick(3);
        check("toggled out", 16'h0001, {15'h0000, outv});
        sel <= 1'h0;
        dsel <= 1'h1;
        repeat (2) exp_q.push_back({1'h1, d});
        run(tmr_pkg::MODE_INTERVAL, d);
        drain();
        dsel <= 1'h0;
        exp_q.push_back({1'h1, d});
        run(tmr_pkg::MODE_EVENT, d);
        tick(1);
        check("event load", d, cnt);
        check("enable flag", 16'h0001, {15'h0000, en});
        repeat (d + 1) i_pin_src.pulse(2, 4);
        drain();
        exp_q.push_back({1'h1, d});
        run(tmr_pkg::MODE_ONECOUNT, d);
        i_pin_src.pulse(2, 4);
        drain();
        check("one-count stop", 16'hffff, cnt);
        n = rnd() % 8 + 8;
        exp_q.push_back(17'h00000);
        repeat (2) exp_q.push_back({1'h1, 16'(n - 1)});
        vedge <= tmr_pkg::EDGE_FALL;
        run(tmr_pkg::MODE_CAPTURE, d);
        repeat (3) i_pin_src.pulse(3, n - 3);
        drain();
        exp_q.push_back({1'h1, 16'(n - 1)});
        run(tmr_pkg::MODE_CAP_ONE, d);
        i_pin_src.pulse(n, 6);
        drain();
        for (int p = 0; p < 2; p++) begin
            oen <= 1'h0;
            omode <= 1'h1;
            opol <= p[0];
            owe <= 1'h1;
            owr <= p[0];
            tick(1);
            owe <= 1'h0;
            oen <= 1'h1;
            mi <= 1'h1;
            tick(1);
            mi <= 1'h0;
            tick(4);
            check("slave out", {15'h0000, ~p[0]}, {15'h0000, outv});
        end
        oen <= 1'h0;
        opol <= 1'h0;
        owe <= 1'h1;
        owr <= 1'h1;
        tick(1);
        owe <= 1'h0;
        oen <= 1'h1;
        sel <= 1'h1;
        exp_q.push_back({1'h1, d});
        run(tmr_pkg::MODE_INTERVAL, d);
        tick(1);
        mi <= 1'h1;
        tick(1);
        mi <= 1'h0;
        drain();
        tick(2);
        check("both events", 16'h0000, {15'h0000, outv});
        b = rnd();
        oen <= 1'h0;
        owe <= 1'h1;
        owr <= b[0];
        tick(1);
        owe <= 1'h0;
        mi <= 1'h1;
        tick(1);
        mi <= 1'h0;
        tick(4);
        check("written out", {15'h0000, b[0]}, {15'h0000, outv});
        summarize();
    end
endmodule
